// File: core/can_status_pkg.sv
// Constants for the CAN status, interrupt, receive queue and bit timing block.
// Assumes an AXI4-Lite master with 32-bit data; each register is one word at four times its index.
package can_status_pkg;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 17;
  localparam logic [15:0] IDX_MODE     = 16'hAB00;
  localparam logic [15:0] IDX_COMMAND  = 16'hAB01;
  localparam logic [15:0] IDX_STATUS   = 16'hAB02;
  localparam logic [15:0] IDX_FLAGS    = 16'hAB03;
  localparam logic [15:0] IDX_ENABLES  = 16'hAB04;
  localparam logic [15:0] IDX_START    = 16'hAB05;
  localparam logic [15:0] IDX_STOP     = 16'hAB06;
  localparam logic [15:0] IDX_WP_LOW   = 16'hAB07;
  localparam logic [15:0] IDX_WP_HIGH  = 16'hAB08;
  localparam logic [15:0] IDX_PRESCALE = 16'hAB09;
  localparam logic [15:0] IDX_SEGMENTS = 16'hAB0A;
  localparam logic [15:0] IDX_FILTERS  = 16'hAB0F;
  localparam logic [15:0] IDX_TX_BUF   = 16'hAB17;
  // Flag and enable bit positions.
  localparam int F_BUS_ERR = 7;
  localparam int F_ARB     = 6;
  localparam int F_PASSIVE = 5;
  localparam int F_BUS_OFF = 4;
  localparam int F_OVERRUN = 3;
  localparam int F_WARN    = 2;
  localparam int F_TX      = 1;
  localparam int F_RX      = 0;
  // Status bit positions.
  localparam int S_BUS_OFF = 7;
  localparam int S_WARN    = 6;
  localparam int S_TX_ACT  = 5;
  localparam int S_RX_ACT  = 4;
  localparam int S_TX_DONE = 3;
  localparam int S_TX_FREE = 2;
  localparam int S_OVERRUN = 1;
  localparam int S_RX_AVL  = 0;
  // Command bit positions.
  localparam int C_SELF_RX   = 4;
  localparam int C_CLR_OVR   = 3;
  localparam int C_CLR_RXAVL = 2;
  localparam int C_ABORT     = 1;
  localparam int C_SEND      = 0;
  localparam int M_RESET     = 0;
  localparam logic [7:0] MODE_RESET_VAL = 8'h01;
  localparam logic [7:0] REG_RESET_VAL  = 8'h00;
  // Bit timing field layout.
  localparam int PS_MSB  = 5;
  localparam int SJW_MSB = 7;
  localparam int SJW_LSB = 6;
  localparam int PH1_MSB = 3;
  localparam int PH2_MSB = 6;
  localparam int PH2_LSB = 4;
  localparam int SAM_BIT = 7;
  localparam int RECORD_BYTES = 16;
  localparam int BYTE_CNT_W   = 4;
  localparam int PTR_W        = 9;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic [1:0] {DMA_IDLE = 2'b00, DMA_XFER = 2'b01, DMA_DONE = 2'b11} dma_state_e;
  typedef enum logic [1:0] {BT_SYNC = 2'b00, BT_PH1 = 2'b01, BT_PH2 = 2'b11} bit_state_e;
endpackage

// File: core/can_status_core.sv
// Status, interrupt flags, receive queue DMA, bit timing and filter enables of a CAN controller.
// Assumes a protocol engine that reports events as one-cycle pulses and levels, and a RAM port that grants stolen cycles.
//
// Summary of operation
// [R1] Send or self-receive clears tx_complete; completion or abort sets it.
// [R2] Transmit buffer writes while locked are discarded and flag a disruption.
// [R3] Each accepted message becomes a 16-byte record; pointer then advances one frame.
// [R4] Passing the stop address reloads start, sets overrun status and overrun flag.
// [R5] Overrun and rx_available stay set until their clear command or reset mode.
// [R6] Other status bits follow their condition or clear when status is read.
// [R7] Flag register is read-only, read clears all but bus-off; flags set on change.
// [R8] Flags act only when enabled; bus error bit 7 down to receive bit 0.
// [R9] Bus errors set bus_error_flag; lost arbitration sets arb_lost_flag.
// [R10] Entering or leaving error passive sets error_passive_flag.
// [R11] Bus-off flag holds through bus-off; software must mask it in the handler.
// [R12] Warning status rising, error count at or above limit, sets error_warning_flag.
// [R13] Buffer freed after a message sets tx_flag; stored message sets rx_flag.
// [R14] Records reach CPU data RAM by DMA in cycles the CPU leaves free.
// [R15] Start and stop hold address bits 12..5; start change reloads pointer.
// [R16] Software keeps stop above start; queue holds 2*(stop-start+1) frames.
// [R17] Pointer holds bits 12..4, split low/high, wraps at bit4 set and stop match.
// [R18] Quantum clock is system clock over 2*(prescale+1).
// [R19] Resync inserts a compensation segment of at most jump_width+1 quanta.
// [R20] Bit time is sync plus phase one plus phase two quanta.
// [R21] Single sample at phase two start, or majority of it and the two quanta before.
// [R22] Four filter enables, writable only in reset mode.
// [R23] reset_mode_bit resets state machines, keeps registers, defaults to one.
// [R24] One interrupt output ORs all enabled flags.
`timescale 1ns/1ps
module can_status_core
  import can_status_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         tx_done,
  input  wire logic         abort_done,
  input  wire logic         tx_active,
  input  wire logic         rx_active,
  input  wire logic         bus_error,
  input  wire logic         arb_lost,
  input  wire logic         error_passive,
  input  wire logic         bus_off_status,
  input  wire logic [7:0]   rx_error_count,
  input  wire logic [7:0]   tx_error_count,
  input  wire logic [7:0]   warning_limit,
  input  wire logic         rx_valid,
  input  wire logic [127:0] rx_record,
  output logic              rx_ready,
  input  wire logic         ram_gnt,
  output logic              ram_req,
  output logic [12:0]       ram_addr,
  output logic [7:0]        ram_wdata,
  input  wire logic         can_rx,
  output logic              quantum_tick,
  output logic              sample_point,
  output logic              sample_bit,
  output logic              send_request_cmd,
  output logic              self_receive_cmd,
  output logic              abort_cmd,
  output logic              tx_disrupt,
  output logic [7:0]        tx_buf_data,
  output logic [3:0]        filter_en,
  output logic              reset_mode_bit,
  output logic              irq
);
  logic [7:0]  flags_reg, en_reg, start_reg, stop_reg, prescale_reg, segments_reg;
  logic        tx_complete_reg, tx_free_reg, overrun_reg, rx_avl_reg;
  logic [PTR_W-1:0] wp_reg;
  logic [31:0] aw_addr_reg, w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_held, w_held;
  logic        wr_go, rd_go, wlow;
  logic [15:0] wr_idx, rd_idx;
  logic [7:0]  wbyte, rdat;
  logic        rd_hit;

  // Write address and data are taken independently; the write acts once both are held.
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr_reg[ADDR_MSB:ADDR_LSB];
  assign wbyte  = w_data_reg[7:0];
  assign wlow   = wr_go && w_strb_reg[0];
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[ADDR_MSB:ADDR_LSB];

  function automatic logic known(input logic [15:0] idx);
    known = idx inside {IDX_MODE, IDX_COMMAND, IDX_STATUS, IDX_FLAGS, IDX_ENABLES, IDX_START, IDX_STOP,
                        IDX_WP_LOW, IDX_WP_HIGH, IDX_PRESCALE, IDX_SEGMENTS, IDX_FILTERS, IDX_TX_BUF};
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= 32'h0000_0000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(wr_idx) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // Register writes and commands.
  logic cmd_send, cmd_self, cmd_abort, cmd_clr_ovr, cmd_clr_avl, wr_start;
  assign cmd_send    = wlow && wr_idx == IDX_COMMAND && !reset_mode_bit && (wbyte[C_SEND] || wbyte[C_SELF_RX]);
  assign cmd_self    = cmd_send && wbyte[C_SELF_RX];
  assign cmd_abort   = wlow && wr_idx == IDX_COMMAND && !reset_mode_bit && wbyte[C_ABORT];
  assign cmd_clr_ovr = wlow && wr_idx == IDX_COMMAND && wbyte[C_CLR_OVR];
  assign cmd_clr_avl = wlow && wr_idx == IDX_COMMAND && wbyte[C_CLR_RXAVL];
  assign wr_start    = wlow && wr_idx == IDX_START && wbyte != start_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_mode_bit <= MODE_RESET_VAL[M_RESET]; // [R23]
      en_reg       <= REG_RESET_VAL;
      start_reg    <= REG_RESET_VAL;
      stop_reg     <= REG_RESET_VAL;
      prescale_reg <= REG_RESET_VAL;
      segments_reg <= REG_RESET_VAL;
      filter_en    <= REG_RESET_VAL[3:0];
      tx_buf_data  <= REG_RESET_VAL;
      tx_disrupt   <= 1'b0;
    end else begin
      tx_disrupt <= 1'b0;
      if (wlow) begin
        case (wr_idx)
          IDX_MODE:     reset_mode_bit <= wbyte[M_RESET];
          IDX_ENABLES:  en_reg <= wbyte;
          IDX_START:    start_reg <= wbyte;
          IDX_STOP:     stop_reg <= wbyte;
          IDX_PRESCALE: prescale_reg <= wbyte;
          IDX_SEGMENTS: segments_reg <= wbyte;
          IDX_FILTERS: begin
            if (reset_mode_bit) filter_en <= wbyte[3:0]; // [R22]
          end
          IDX_TX_BUF: begin
            if (tx_free_reg) tx_buf_data <= wbyte;
            else tx_disrupt <= 1'b1; // [R2]
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send_request_cmd <= 1'b0;
      self_receive_cmd <= 1'b0;
      abort_cmd        <= 1'b0;
    end else begin
      send_request_cmd <= cmd_send && !cmd_self;
      self_receive_cmd <= cmd_self;
      abort_cmd        <= cmd_abort;
    end
  end

  // Transmit status. Completion in the command cycle wins over the clear.
  logic st_read, fl_read;
  assign st_read = rd_go && rd_idx == IDX_STATUS;
  assign fl_read = rd_go && rd_idx == IDX_FLAGS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_complete_reg <= 1'b1;
      tx_free_reg     <= 1'b1;
    end else begin
      if (tx_done || abort_done) tx_complete_reg <= 1'b1; // [R1]
      else if (cmd_send || st_read) tx_complete_reg <= 1'b0; // [R1] [R6]
      if (tx_done || abort_done || reset_mode_bit) tx_free_reg <= 1'b1;
      else if (cmd_send) tx_free_reg <= 1'b0;
    end
  end

  // Receive queue DMA, one byte per granted RAM cycle.
  dma_state_e dma_state;
  logic [127:0] rec_reg;
  logic [BYTE_CNT_W-1:0] byte_cnt;
  logic wrap, stored;
  assign wrap   = wp_reg[0] && wp_reg[PTR_W-1:1] == stop_reg; // [R17]
  assign stored = dma_state == DMA_DONE;
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_mode_bit) begin
      dma_state <= DMA_IDLE;
      rec_reg   <= 128'h0;
      byte_cnt  <= '0;
      rx_ready  <= 1'b0;
      ram_req   <= 1'b0;
      ram_addr  <= 13'h0000;
      ram_wdata <= 8'h00;
    end else begin
      case (dma_state)
        DMA_IDLE: begin
          rx_ready <= 1'b1;
          if (rx_valid && rx_ready) begin
            rx_ready  <= 1'b0;
            rec_reg   <= rx_record;
            byte_cnt  <= '0;
            ram_req   <= 1'b1; // [R14]
            ram_addr  <= {wp_reg, 4'h0}; // [R3]
            ram_wdata <= rx_record[7:0];
            dma_state <= DMA_XFER;
          end
        end
        DMA_XFER: begin
          if (ram_gnt) begin
            if (byte_cnt == BYTE_CNT_W'(RECORD_BYTES - 1)) begin
              ram_req   <= 1'b0;
              dma_state <= DMA_DONE;
            end else begin
              byte_cnt  <= byte_cnt + 1'b1;
              ram_addr  <= {wp_reg, byte_cnt + 1'b1};
              ram_wdata <= rec_reg[8*(byte_cnt + 1'b1) +: 8];
            end
          end
        end
        DMA_DONE: dma_state <= DMA_IDLE;
        default:  dma_state <= DMA_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) wp_reg <= '0;
    else if (wr_start) wp_reg <= {wbyte, 1'b0}; // [R15]
    else if (stored && wrap) wp_reg <= {start_reg, 1'b0}; // [R4]
    else if (stored) wp_reg <= wp_reg + 1'b1; // [R3]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_reg <= 1'b0;
      rx_avl_reg  <= 1'b0;
    end else begin
      if (stored && wrap) overrun_reg <= 1'b1; // [R4]
      else if (cmd_clr_ovr || reset_mode_bit) overrun_reg <= 1'b0; // [R5]
      if (stored) rx_avl_reg <= 1'b1;
      else if (cmd_clr_avl || reset_mode_bit) rx_avl_reg <= 1'b0; // [R5]
    end
  end

  // Interrupt flags: edge-triggered except bus-off, which follows its level.
  logic warn_now, warn_prev, passive_prev, free_prev, ovr_prev;
  logic [7:0] ev;
  assign warn_now = rx_error_count >= warning_limit || tx_error_count >= warning_limit;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_prev    <= 1'b0;
      passive_prev <= 1'b0;
      free_prev    <= 1'b1;
      ovr_prev     <= 1'b0;
    end else begin
      warn_prev    <= warn_now;
      passive_prev <= error_passive;
      free_prev    <= tx_free_reg;
      ovr_prev     <= overrun_reg;
    end
  end
  always_comb begin
    ev = 8'h00;
    ev[F_BUS_ERR] = bus_error; // [R9]
    ev[F_ARB]     = arb_lost; // [R9]
    ev[F_PASSIVE] = error_passive != passive_prev; // [R10]
    ev[F_BUS_OFF] = bus_off_status; // [R11]
    ev[F_OVERRUN] = overrun_reg && !ovr_prev;
    ev[F_WARN]    = warn_now && !warn_prev; // [R12]
    ev[F_TX]      = tx_free_reg && !free_prev; // [R13]
    ev[F_RX]      = stored; // [R13]
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_reg <= REG_RESET_VAL;
    else if (fl_read) flags_reg <= ev & en_reg; // [R7] [R8]
    else flags_reg <= flags_reg | (ev & en_reg); // [R8]
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(flags_reg & en_reg); // [R24]
  end

  // Read channel.
  always_comb begin
    rdat   = 8'h00;
    rd_hit = known(rd_idx);
    case (rd_idx)
      IDX_MODE:     rdat[M_RESET] = reset_mode_bit;
      IDX_STATUS:   rdat = {bus_off_status, warn_now, tx_active, rx_active, tx_complete_reg, tx_free_reg,
                            overrun_reg, rx_avl_reg}; // [R6]
      IDX_FLAGS:    rdat = flags_reg;
      IDX_ENABLES:  rdat = en_reg;
      IDX_START:    rdat = start_reg;
      IDX_STOP:     rdat = stop_reg;
      IDX_WP_LOW:   rdat = wp_reg[7:0]; // [R17]
      IDX_WP_HIGH:  rdat[0] = wp_reg[PTR_W-1]; // [R17]
      IDX_PRESCALE: rdat = prescale_reg;
      IDX_SEGMENTS: rdat = segments_reg;
      IDX_FILTERS:  rdat = {4'h0, filter_en};
      IDX_TX_BUF:   rdat = tx_buf_data;
      default:      rdat = 8'h00;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rdat};
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Quantum prescaler: a period of 2*(prescale+1) system clocks.
  logic [6:0] pre_cnt;
  logic [6:0] pre_lim;
  assign pre_lim = {prescale_reg[PS_MSB:0], 1'b1};
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_mode_bit) begin
      pre_cnt      <= 7'h00;
      quantum_tick <= 1'b0;
    end else begin
      quantum_tick <= pre_cnt == pre_lim; // [R18]
      pre_cnt      <= (pre_cnt == pre_lim) ? 7'h00 : pre_cnt + 1'b1;
    end
  end

  // Bit timer. Phase one is stretched by the compensation extension on resync.
  bit_state_e bt_state;
  logic [4:0] qc, ext, ph1_end, nxt;
  logic [2:0] sjw1;
  logic [3:0] ph2_end;
  logic       comp_used, rx_prev, s_a, s_b;
  assign sjw1    = {1'b0, prescale_reg[SJW_MSB:SJW_LSB]} + 3'd1;
  assign ph1_end = 5'(segments_reg[PH1_MSB:0]) + ext; // [R20]
  assign ph2_end = {1'b0, segments_reg[PH2_MSB:PH2_LSB]}; // [R20]
  assign nxt     = (bt_state == BT_SYNC) ? 5'd0 : qc + 1'b1;
  always_ff @(posedge aclk) begin
    if (!aresetn || reset_mode_bit) begin
      bt_state     <= BT_SYNC;
      qc           <= 5'd0;
      ext          <= 5'd0;
      comp_used    <= 1'b0;
      rx_prev      <= 1'b1;
      s_a          <= 1'b1;
      s_b          <= 1'b1;
      sample_point <= 1'b0;
      sample_bit   <= 1'b1;
    end else begin
      sample_point <= 1'b0;
      rx_prev      <= can_rx;
      if (bt_state == BT_PH1 && rx_prev && !can_rx && !comp_used) begin
        comp_used <= 1'b1;
        ext <= (qc + 1'b1 < 5'(sjw1)) ? qc + 1'b1 : 5'(sjw1); // [R19]
      end
      if (quantum_tick) begin
        if (bt_state != BT_PH2 && nxt == ph1_end - 5'd1) s_a <= can_rx; // [R21]
        if (bt_state != BT_PH2 && nxt == ph1_end) s_b <= can_rx; // [R21]
        case (bt_state)
          BT_SYNC: begin
            bt_state <= BT_PH1;
            qc <= 5'd0;
          end
          BT_PH1: begin
            if (qc == ph1_end) begin
              bt_state     <= BT_PH2;
              qc           <= 5'd0;
              sample_point <= 1'b1;
              if (segments_reg[SAM_BIT])
                sample_bit <= (s_a & s_b) | (s_a & can_rx) | (s_b & can_rx); // [R21]
              else sample_bit <= can_rx; // [R21]
            end else qc <= qc + 1'b1;
          end
          BT_PH2: begin
            if (qc == 5'(ph2_end)) begin
              bt_state  <= BT_SYNC;
              ext       <= 5'd0;
              comp_used <= 1'b0;
            end else qc <= qc + 1'b1;
          end
          default: bt_state <= BT_SYNC;
        endcase
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_output_a: assert property (##1 irq == $past(|(flags_reg & en_reg))) // [R24]
    else $error("irq does not follow enabled flags");
  tx_clear_a: assert property (cmd_send && !tx_done && !abort_done |=> !tx_complete_reg && !tx_free_reg) // [R1]
    else $error("send command did not clear transmit status");
  tx_discard_a: assert property (wlow && wr_idx == IDX_TX_BUF && !tx_free_reg |=> $stable(tx_buf_data) && tx_disrupt) // [R2]
    else $error("locked transmit buffer was written");
  ptr_step_a: assert property (stored && !wrap && !wr_start |=> wp_reg == $past(wp_reg) + 1'b1) // [R3]
    else $error("write pointer did not advance one frame");
  ptr_wrap_a: assert property (stored && wrap && !wr_start |=> wp_reg == {start_reg, 1'b0} && overrun_reg) // [R4]
    else $error("wrap did not reload start and set overrun");
  reset_clear_a: assert property (reset_mode_bit && !stored |=> !overrun_reg && !rx_avl_reg) // [R5]
    else $error("reset mode left receive status set");
  bus_off_hold_a: assert property (bus_off_status && en_reg[F_BUS_OFF] |=> flags_reg[F_BUS_OFF]) // [R11]
    else $error("bus-off flag dropped during bus-off");
  filter_lock_a: assert property (!$stable(filter_en) |-> $past(reset_mode_bit)) // [R22]
    else $error("filter enables changed outside reset mode");
  start_copy_a: assert property (wr_start |=> wp_reg == {$past(wbyte), 1'b0}) // [R15]
    else $error("start change did not reload pointer");
  quantum_gap_a: assert property (quantum_tick |=> !quantum_tick) // [R18]
    else $error("quantum ticks back to back");
endmodule

// File: bench/ram_model.sv
// Byte-wide model of the CPU data RAM that the receive DMA writes into.
// Assumes the DMA holds request, address and data until a granted edge.
`timescale 1ns/1ps
module ram_model (
  input  wire logic        aclk,
  input  wire logic        ram_req,
  input  wire logic [12:0] ram_addr,
  input  wire logic [7:0]  ram_wdata,
  output logic             ram_gnt
);
  logic [7:0] mem [0:8191];
  initial ram_gnt = 1'b0;
  // Granting only every other cycle stands in for the CPU winning the RAM.
  always @(posedge aclk) begin
    ram_gnt <= ram_req && !ram_gnt;
    if (ram_req && ram_gnt) begin
      mem[ram_addr] <= ram_wdata;
    end
  end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the CAN status block: registers, receive queue, flags and interrupt.
// Assumes the block's package and a RAM model that grants stolen cycles.
`timescale 1ns/1ps
module tb_top;
  import can_status_pkg::*;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0]   s_axi_wstrb, filter_en;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         tx_done, abort_done, tx_active, rx_active, bus_error, arb_lost, error_passive, bus_off_status;
  logic [7:0]   rx_error_count, tx_error_count, warning_limit, ram_wdata, tx_buf_data;
  logic         rx_valid, rx_ready, ram_gnt, ram_req, can_rx, quantum_tick, sample_point, sample_bit;
  logic         send_request_cmd, self_receive_cmd, abort_cmd, tx_disrupt, reset_mode_bit, irq;
  logic [127:0] rx_record;
  logic [12:0]  ram_addr;
  int           mismatches, comparisons, cyc, nq, ns;
  bit   [3:0]   seen;

  can_status_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_done,
    .abort_done, .tx_active, .rx_active, .bus_error, .arb_lost, .error_passive, .bus_off_status,
    .rx_error_count, .tx_error_count, .warning_limit, .rx_valid, .rx_record, .rx_ready, .ram_gnt, .ram_req,
    .ram_addr, .ram_wdata, .can_rx, .quantum_tick, .sample_point, .sample_bit, .send_request_cmd,
    .self_receive_cmd, .abort_cmd, .tx_disrupt, .tx_buf_data, .filter_en, .reset_mode_bit, .irq);
  ram_model i_ram (.aclk, .ram_req, .ram_addr, .ram_wdata, .ram_gnt);

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    bit a, w;
    a = 0;
    w = 0;
    s_axi_awaddr <= {14'h0, i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && !a) begin a = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !w) begin w = 1; s_axi_wvalid <= 1'b0; end
    end while (!(a && w));
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [15:0] i);
    s_axi_araddr <= {14'h0, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic rx_frame(input logic [7:0] b);
    for (int n = 0; n < 16; n++) rx_record[n*8 +: 8] <= b + 8'(n);
    rx_valid <= 1'b1;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'b0;
    do @(posedge aclk); while (!rx_ready);
  endtask

  task automatic t_reset;
    logic [15:0] idx [9] = '{IDX_FLAGS, IDX_ENABLES, IDX_START, IDX_STOP, IDX_WP_LOW, IDX_WP_HIGH,
                             IDX_PRESCALE, IDX_SEGMENTS, IDX_FILTERS};
    foreach (idx[k]) begin rd(idx[k]); chk(rdat, 32'h0); end
    rd(IDX_MODE); chk(rdat, 32'h1);
    rd(IDX_STATUS); chk(rdat, 32'h0C);
    rd(IDX_STATUS); chk(rdat, 32'h04);
    rd(16'hAB0B); chk(rdat, 32'h0);
    chk(32'(rsp), 32'(RESP_DECERR));
  endtask

  task automatic t_filters;
    wr(IDX_FILTERS, 8'h0A);
    wr(IDX_MODE, 8'h00);
    wr(IDX_FILTERS, 8'h05);
    rd(IDX_FILTERS); chk(rdat, 32'h0A);
  endtask

  task automatic t_rx;
    wr(IDX_START, 8'h02);
    wr(IDX_STOP, 8'h03);
    wr(IDX_ENABLES, 8'h09);
    rd(IDX_WP_LOW); chk(rdat, 32'h04);
    for (int k = 0; k < 4; k++) begin
      rx_frame(8'(16 * k));
      rd(IDX_WP_LOW); chk(rdat, k < 3 ? 32'(5 + k) : 32'h04);
      rd(IDX_STATUS); chk(rdat & 32'h3, k < 3 ? 32'h1 : 32'h3);
      chk(32'(irq), 32'h1);
      rd(IDX_FLAGS); chk(rdat, k < 3 ? 32'h01 : 32'h09);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
    end
    for (int j = 0; j < 64; j++) chk(32'(i_ram.mem[13'h40 + j]), 32'(j));
    wr(IDX_COMMAND, 8'h08);
    rd(IDX_STATUS); chk(rdat & 32'h3, 32'h1);
    wr(IDX_COMMAND, 8'h04);
    rd(IDX_STATUS); chk(rdat & 32'h3, 32'h0);
  endtask

  task automatic t_errors;
    wr(IDX_ENABLES, 8'hF4);
    {bus_error, arb_lost, error_passive, bus_off_status, tx_done} <= 5'h1F;
    rx_error_count <= 8'h60;
    @(posedge aclk);
    {bus_error, arb_lost, tx_done} <= 3'h0;
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    rd(IDX_FLAGS); chk(rdat, 32'hF4);
    rd(IDX_FLAGS); chk(rdat, 32'h10);
    wr(IDX_ENABLES, 8'h00);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_tx;
    wr(IDX_ENABLES, 8'h02);
    wr(IDX_TX_BUF, 8'h5A);
    wr(IDX_COMMAND, 8'h01);
    rd(IDX_STATUS); chk(rdat & 32'hC, 32'h0);
    wr(IDX_TX_BUF, 8'hA5);
    chk(32'(tx_buf_data), 32'h5A);
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
    rd(IDX_STATUS); chk(rdat & 32'hC, 32'hC);
    rd(IDX_FLAGS); chk(rdat, 32'h02);
    wr(IDX_COMMAND, 8'h10);
    wr(IDX_COMMAND, 8'h02);
    @(posedge aclk);
    chk(32'(seen), 32'hF);
  endtask

  // Windows are whole multiples of both tick and bit periods, so the counts do not depend on phase.
  task automatic t_timing;
    int q, s;
    wr(IDX_PRESCALE, 8'h01);
    wr(IDX_SEGMENTS, 8'h92);
    repeat (48) @(posedge aclk);
    q = nq;
    s = ns;
    repeat (240) @(posedge aclk);
    chk(32'(nq - q), 32'h3C);
    chk(32'(ns - s), 32'hA);
    can_rx <= 1'b0;
    repeat (48) @(posedge aclk);
    chk(32'(sample_bit), 32'h0);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    seen <= seen | {tx_disrupt, abort_cmd, self_receive_cmd, send_request_cmd};
    nq   <= nq + int'(quantum_tick);
    ns   <= ns + int'(sample_point);
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end

  initial begin
    aresetn <= 1'b0;
    // Both response readies stay high for the whole run, so back-to-back calls never toggle them.
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h05;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
    s_axi_wstrb <= 4'hF;
    {tx_done, abort_done, tx_active, rx_active, bus_error, arb_lost, error_passive, bus_off_status} <= '0;
    {rx_error_count, tx_error_count} <= '0;
    warning_limit <= 8'h60;
    {rx_valid, rx_record} <= '0;
    can_rx <= 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_filters;
    t_rx;
    t_tx;
    t_timing;
    t_errors;
    report_and_stop;
  end
endmodule
